// File: hdl/paired_timer.sv
// Purpose: Two timer pairs, 16-bit or 32-bit, on an APB slave
// Assumes: idle_mode and sleep_mode come from ref_clk logic
// Notes: Zero-wait APB; timers 0,1 form pair A, timers 2,3 pair B
// Contract
// - Two pairs, each one 32-bit timer or two 16-bit timers.
// - Pair modes: two 16-bit timers, 32-bit timer, 32-bit counter.
// - Each 16-bit timer counts the clock or external events.
// - Gating, prescaler, low-power running, match flags per timer.
// - 32-bit mode flags when 32-bit count equals 32-bit period.
// - Timers may keep running in idle and sleep as configured.
// - Only pair A offers its count as capture/compare time base.
// - Converter trigger only from 32-bit pairs and high timers.
// - Each pair's mode comes from its low timer's control register.
// - In a pair the low timer holds bits 15:0, high 31:16.
// - In 32-bit mode high control bits are ignored.
// - In 32-bit mode the low timer's clock and gate drive the pair.
// - 32-bit match sets the high timer's flag, not the low.
// - Only these four timers raise DMA requests.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "timer_cfg.svh"
module paired_timer (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic idle_mode,
   input wire logic sleep_mode,
   input wire logic [3:0] ext_clk_pin,
   input wire logic [3:0] gate_pin,
   output logic [3:0] timer_flag,
   output logic [3:0] dma_req,
   output logic converter_trigger_target,
   output timer_pkg::word_t tb_count_low,
   output timer_pkg::word_t tb_count_high
);
   import timer_pkg::*;

   logic [15:0] ctrl_ff [0:3];
   logic [15:0] per_ff [0:3];
   logic [15:0] cnt [0:3];
   logic [3:0] tick;
   logic [3:0] hit;
   logic [3:0] run;
   logic [3:0] wr_cnt;
   logic [3:0] flag_ff;
   logic [3:0] dma_ff;
   logic trig_ff;
   logic [15:0] tb_low_ff;
   logic [15:0] tb_high_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] rd_data;
   logic addr_ok;
   logic wr;
   logic [3:0] blk;
   logic [3:0] sub;

   // APB decode
   assign blk = paddr[7:4];
   assign sub = paddr[3:0];
   assign wr = psel & penable & pready_ff & pwrite & ~pslverr_ff;

   always_comb
   begin
      rd_data = 32'h0000_0000;
      addr_ok = 1'b0;
      if (blk[3:2] == 2'b00)
      begin
         case (sub)
            `CTRL_OFF:
            begin
               addr_ok = 1'b1;
               rd_data = {16'h0000, ctrl_ff[blk[1:0]]};
            end
            `COUNT_OFF:
            begin
               addr_ok = 1'b1;
               rd_data = {16'h0000, cnt[blk[1:0]]};
            end
            `PERIOD_OFF:
            begin
               addr_ok = 1'b1;
               rd_data = {16'h0000, per_ff[blk[1:0]]};
            end
            default:
            begin
               addr_ok = 1'b0;
               rd_data = 32'h0000_0000;
            end
         endcase
      end
      else if (blk == `FLAG_BLK && sub == `FLAG_OFF)
      begin
         addr_ok = 1'b1;
         rd_data = {28'h000_0000, flag_ff};
      end
   end

   // Answer in the first access cycle
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pready_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end
      else
      begin
         pready_ff <= psel & ~penable;
         if (psel && !penable)
         begin
            prdata_ff <= pwrite ? 32'h0000_0000 : rd_data;
            pslverr_ff <= ~addr_ok;
         end
      end
   end

   // Per-timer control, period, pins and prescaler
   genvar i;
   generate
      for (i = 0; i < 4; i++)
      begin : g_tmr
         localparam int LO = i - (i % 2);
         logic ext_rise;
         logic gate_lvl;
         logic src;
         logic slave32;
         logic sel_me;

         assign sel_me = wr && (blk[3:2] == 2'b00) && (blk[1:0] == 2'(i));
         assign wr_cnt[i] = sel_me && (sub == `COUNT_OFF);

         always_ff @(posedge ref_clk or negedge resetn)
         begin
            if (!resetn)
            begin
               ctrl_ff[i] <= `CTRL_RST;
               per_ff[i] <= `PERIOD_RST;
            end
            else
            begin
               if (sel_me && sub == `CTRL_OFF)
                  ctrl_ff[i] <= pwdata[15:0] &
                     ((i % 2 == 0) ? `CTRL_LO_MASK : `CTRL_HI_MASK);
               if (sel_me && sub == `PERIOD_OFF)
                  per_ff[i] <= pwdata[15:0];
            end
         end

         pin_sync u_sync (
            .ref_clk(ref_clk),
            .resetn(resetn),
            .ext_clk_in(ext_clk_pin[i]),
            .gate_in(gate_pin[i]),
            .ext_rise(ext_rise),
            .gate_level(gate_lvl)
         );

         // External events, gated clock or plain clock
         always_comb
         begin
            if (ctrl_ff[i][`CTRL_EXT_BIT])
               src = ext_rise;
            else if (ctrl_ff[i][`CTRL_GATE_BIT])
               src = gate_lvl;
            else
               src = 1'b1;
         end

         // Idle stops only if asked; sleep stops the internal clock only
         assign run[i] = ctrl_ff[i][`CTRL_ON_BIT]
            & ~(idle_mode & ctrl_ff[i][`CTRL_IDLE_STOP_BIT])
            & ~(sleep_mode & ~ctrl_ff[i][`CTRL_EXT_BIT]);
         assign slave32 = (i % 2 == 1) && ctrl_ff[LO][`CTRL_T32_BIT];

         prescaler u_ps (
            .ref_clk(ref_clk),
            .resetn(resetn),
            .in_pulse(run[i] & src),
            .clear(~run[i] | slave32),
            .sel(presc_t'(ctrl_ff[i][`CTRL_PS_HI:`CTRL_PS_LO])),
            .tick(tick[i])
         );

         AST_GATE_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn)
            ctrl_ff[i][`CTRL_GATE_BIT] && !ctrl_ff[i][`CTRL_EXT_BIT] && !gate_lvl
            |-> !tick[i])
            else $error("Timer ticked with gate low");
         AST_IDLE_STOP: assert property (@(posedge ref_clk) disable iff (!resetn)
            idle_mode && ctrl_ff[i][`CTRL_IDLE_STOP_BIT] |-> !tick[i])
            else $error("Timer ticked in idle with stop set");
         AST_DMA_FLAG: assert property (@(posedge ref_clk) disable iff (!resetn)
            dma_ff[i] |-> flag_ff[i] && $past(hit[i]))
            else $error("DMA request without a match");
      end
   endgenerate

   // Counting per pair
   genvar p;
   generate
      for (p = 0; p < 2; p++)
      begin : g_pair
         localparam int L = 2 * p;
         localparam int H = 2 * p + 1;
         logic [15:0] lo_ff;
         logic [15:0] hi_ff;
         logic [15:0] nxt_lo;
         logic [15:0] nxt_hi;
         logic [31:0] sum32;
         logic m32;
         logic match32;
         logic hit_lo;
         logic hit_hi;

         assign m32 = ctrl_ff[L][`CTRL_T32_BIT];
         assign match32 = {hi_ff, lo_ff} == {per_ff[H], per_ff[L]};
         assign sum32 = {hi_ff, lo_ff} + 32'h0000_0001;

         always_comb
         begin
            nxt_lo = lo_ff;
            nxt_hi = hi_ff;
            hit_lo = 1'b0;
            hit_hi = 1'b0;
            if (m32)
            begin
               // Low timer clock and gate drive both words
               if (tick[L])
               begin
                  if (match32)
                  begin
                     nxt_lo = 16'h0000;
                     nxt_hi = 16'h0000;
                     hit_hi = 1'b1;
                  end
                  else
                  begin
                     nxt_lo = sum32[15:0];
                     nxt_hi = sum32[31:16];
                  end
               end
            end
            else
            begin
               if (tick[L])
               begin
                  hit_lo = (lo_ff == per_ff[L]);
                  nxt_lo = hit_lo ? 16'h0000 : lo_ff + 16'h0001;
               end
               if (tick[H])
               begin
                  hit_hi = (hi_ff == per_ff[H]);
                  nxt_hi = hit_hi ? 16'h0000 : hi_ff + 16'h0001;
               end
            end
            if (wr_cnt[L])
               nxt_lo = pwdata[15:0];
            if (wr_cnt[H])
               nxt_hi = pwdata[15:0];
         end

         always_ff @(posedge ref_clk or negedge resetn)
         begin
            if (!resetn)
            begin
               lo_ff <= `COUNT_RST;
               hi_ff <= `COUNT_RST;
            end
            else
            begin
               lo_ff <= nxt_lo;
               hi_ff <= nxt_hi;
            end
         end

         assign cnt[L] = lo_ff;
         assign cnt[H] = hi_ff;
         assign hit[L] = hit_lo;
         assign hit[H] = hit_hi;

         AST_MATCH16: assert property (@(posedge ref_clk) disable iff (!resetn)
            !m32 && tick[L] && lo_ff == per_ff[L] && !wr_cnt[L]
            |=> lo_ff == 16'h0000 && flag_ff[L])
            else $error("16-bit match did not clear and flag");
         AST_CARRY32: assert property (@(posedge ref_clk) disable iff (!resetn)
            m32 && tick[L] && !match32 && lo_ff == 16'hFFFF && !wr_cnt[L] && !wr_cnt[H]
            |=> lo_ff == 16'h0000 && hi_ff == $past(hi_ff) + 16'h0001)
            else $error("Low word wrap did not carry");
         AST_MATCH32: assert property (@(posedge ref_clk) disable iff (!resetn)
            m32 && tick[L] && match32 && !wr_cnt[L] && !wr_cnt[H]
            |=> flag_ff[H] && {hi_ff, lo_ff} == 32'h0000_0000)
            else $error("32-bit match missed");
         AST_NO_LO_FLAG32: assert property (@(posedge ref_clk) disable iff (!resetn)
            m32 |-> !hit_lo)
            else $error("Low flag raised in 32-bit mode");
         AST_HI_IGNORED: assert property (@(posedge ref_clk) disable iff (!resetn)
            m32 && !tick[L] && !wr_cnt[H] |=> hi_ff == $past(hi_ff))
            else $error("High word moved on its own in 32-bit mode");
         COV_MATCH32: cover property (@(posedge ref_clk) disable iff (!resetn)
            m32 && hit_hi);
         COV_MATCH16: cover property (@(posedge ref_clk) disable iff (!resetn)
            !m32 && hit_lo);
      end
   endgenerate

   // Flags, DMA requests, converter trigger, time base
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         flag_ff <= 4'h0;
      else if (wr && blk == `FLAG_BLK && sub == `FLAG_OFF)
         flag_ff <= (flag_ff & ~pwdata[3:0]) | hit;
      else
         flag_ff <= flag_ff | hit;
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         dma_ff <= 4'h0;
         trig_ff <= 1'b0;
      end
      else
      begin
         dma_ff <= hit;
         trig_ff <= hit[1] | hit[3];
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tb_low_ff <= `COUNT_RST;
         tb_high_ff <= `COUNT_RST;
      end
      else
      begin
         tb_low_ff <= g_pair[0].nxt_lo;
         tb_high_ff <= g_pair[0].nxt_hi;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign timer_flag = flag_ff;
   assign dma_req = dma_ff;
   assign converter_trigger_target = trig_ff;
   assign tb_count_low = tb_low_ff;
   assign tb_count_high = tb_high_ff;

   AST_TRIG_SRC: assert property (@(posedge ref_clk) disable iff (!resetn)
      trig_ff |-> $past(hit[1] || hit[3]) && (flag_ff[1] || flag_ff[3]))
      else $error("Converter trigger from a low timer");
   AST_APB_READY: assert property (@(posedge ref_clk) disable iff (!resetn)
      psel && !penable |=> pready_ff ##1 !pready_ff || (psel && !penable))
      else $error("APB answer not in first access cycle");
   AST_CTRL_WRITE: assert property (@(posedge ref_clk) disable iff (!resetn)
      wr && blk == 4'h0 && sub == `CTRL_OFF |=> ctrl_ff[0] == ($past(pwdata[15:0])
      & `CTRL_LO_MASK))
      else $error("Control write not stored");
   COV_TRIG: cover property (@(posedge ref_clk) disable iff (!resetn) trig_ff);
endmodule

// File: hdl/timer_cfg.svh
// Purpose: Offsets, field positions, reset values for the paired timers
// Assumes: APB byte addresses, one 16-byte block per timer
// Notes: Definitions only
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// Register offsets inside a timer block
`define CTRL_OFF 4'h0
`define COUNT_OFF 4'h4
`define PERIOD_OFF 4'h8
// Block number of the flag register
`define FLAG_BLK 4'h4
`define FLAG_OFF 4'h0

// Control field positions
`define CTRL_ON_BIT 15
`define CTRL_IDLE_STOP_BIT 13
`define CTRL_GATE_BIT 6
`define CTRL_PS_HI 5
`define CTRL_PS_LO 4
`define CTRL_T32_BIT 3
`define CTRL_EXT_BIT 1
`define CTRL_LO_MASK 16'hA07A
`define CTRL_HI_MASK 16'hA072

// Reset values
`define CTRL_RST 16'h0000
`define COUNT_RST 16'h0000
`define PERIOD_RST 16'hFFFF

// Prescaler terminal counts
`define PS_LAST_1 8'h00
`define PS_LAST_8 8'h07
`define PS_LAST_64 8'h3F
`define PS_LAST_256 8'hFF

`endif

// File: hdl/timer_pkg.sv
// Purpose: Types shared by the paired timer files
// Assumes: Nothing
// Notes: Constants live in timer_cfg.svh
package timer_pkg;
   typedef enum logic [1:0] {
      PS_DIV1 = 2'b00,
      PS_DIV8 = 2'b01,
      PS_DIV64 = 2'b10,
      PS_DIV256 = 2'b11
   } presc_t;
   typedef logic [15:0] word_t;
endpackage

// File: hdl/pin_sync.sv
// Purpose: Two-stage synchroniser for a timer's clock and gate pins
// Assumes: Pins are asynchronous to ref_clk
// Notes: Rise pulse lasts one cycle
`timescale 1ns/100ps
module pin_sync (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic ext_clk_in,
   input wire logic gate_in,
   output logic ext_rise,
   output logic gate_level
);
   import timer_pkg::*;
   logic [1:0] meta_ff;
   logic [1:0] sync_ff;
   logic clk_old_ff;

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         meta_ff <= 2'h0;
         sync_ff <= 2'h0;
         clk_old_ff <= 1'b0;
      end
      else
      begin
         meta_ff <= {gate_in, ext_clk_in};
         sync_ff <= meta_ff;
         clk_old_ff <= sync_ff[0];
      end
   end

   assign ext_rise = sync_ff[0] & ~clk_old_ff;
   assign gate_level = sync_ff[1];
endmodule

// File: hdl/prescaler.sv
// Purpose: Divides count pulses by 1, 8, 64 or 256
// Assumes: in_pulse is on ref_clk
// Notes: Tick is combinational, same cycle as the last pulse
`timescale 1ns/100ps
`include "timer_cfg.svh"
module prescaler (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic in_pulse,
   input wire logic clear,
   input wire timer_pkg::presc_t sel,
   output logic tick
);
   import timer_pkg::*;
   logic [7:0] div_ff;
   logic [7:0] last;

   always_comb
   begin
      case (sel)
         PS_DIV1: last = `PS_LAST_1;
         PS_DIV8: last = `PS_LAST_8;
         PS_DIV64: last = `PS_LAST_64;
         default: last = `PS_LAST_256;
      endcase
   end

   assign tick = in_pulse & ~clear & (div_ff >= last);

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         div_ff <= 8'h00;
      else if (clear || tick)
         div_ff <= 8'h00;
      else if (in_pulse)
         div_ff <= div_ff + 8'h01;
   end
endmodule

// File: test/pin_source.sv
// Purpose: Far-side model driving the timers' event and gate pins
// Assumes: Pins are asynchronous to the timer clock, edges spaced for the synchroniser
// Notes: Pins idle low; the pins change only while a task runs
`timescale 1ns/100ps
module pin_source (
   input wire logic ref_clk,
   output logic [3:0] ext_clk_pin,
   output logic [3:0] gate_pin
);
   initial
   begin
      ext_clk_pin = 4'h0;
      gate_pin = 4'h0;
   end

   // Rising edges on one event pin, three cycles high, four low
   task edges(input int idx, input int n);
      repeat (n)
      begin
         @(posedge ref_clk);
         ext_clk_pin[idx] <= 1'b1;
         repeat (3) @(posedge ref_clk);
         ext_clk_pin[idx] <= 1'b0;
         repeat (3) @(posedge ref_clk);
      end
   endtask

   // Level on one gate pin, changed at a clock edge
   task gate_set(input int idx, input logic lvl);
      @(posedge ref_clk);
      gate_pin[idx] <= lvl;
   endtask
endmodule

// File: test/tb.sv
// Purpose: Self-checking bench for the paired timers over APB
// Assumes: Zero-wait slave, register map of timer_cfg.svh
// Notes: Pin source stands in for the external event and gate wiring
`timescale 1ns/100ps
module tb;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic idle_mode = 1'b0;
   logic sleep_mode = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready;
   logic pslverr;
   logic err;
   logic converter_trigger_target;
   logic [3:0] ext_clk_pin;
   logic [3:0] gate_pin;
   logic [3:0] timer_flag;
   logic [3:0] dma_req;
   timer_pkg::word_t tb_count_low;
   timer_pkg::word_t tb_count_high;
   int n_mismatch = 0;
   int check_count = 0;
   int dma_n = 0;
   int trig_n = 0;

   always #50 ref_clk = ~ref_clk;

   always @(posedge ref_clk)
   begin
      dma_n <= dma_n + $countones(dma_req);
      trig_n <= trig_n + int'(converter_trigger_target);
   end

   paired_timer u_paired_timer (.ref_clk(ref_clk), .resetn(resetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode), .sleep_mode(sleep_mode),
      .ext_clk_pin(ext_clk_pin), .gate_pin(gate_pin), .timer_flag(timer_flag),
      .dma_req(dma_req), .converter_trigger_target(converter_trigger_target),
      .tb_count_low(tb_count_low), .tb_count_high(tb_count_high));

   pin_source u_pin_source (.ref_clk(ref_clk), .ext_clk_pin(ext_clk_pin), .gate_pin(gate_pin));

   task wrap_up;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One APB transfer, held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      chk(what, exp, rd);
   endtask

   task wflag(input int i);
      int n;
      n = 0;
      while (timer_flag[i] !== 1'b1 && n < 60)
      begin
         @(posedge ref_clk);
         n++;
      end
      chk("flag wait", 32'h00000001, {31'h0, timer_flag[i]});
   endtask

   initial
   begin
      repeat (20) @(posedge ref_clk);
      resetn <= 1'b1;
      rdc("ctrl0 reset", 8'h00, 32'h00000000);
      rdc("count0 reset", 8'h04, 32'h00000000);
      rdc("period0 reset", 8'h08, 32'h0000FFFF);
      apb(1'b0, 8'h4C, 32'h00000000);
      chk("unmapped error", 32'h00000001, {31'h0, err});
      $display("test reset done");
      wr(8'h08, 32'h00000005);
      wr(8'h00, 32'h00008000);
      wflag(0);
      wr(8'h00, 32'h00000000);
      rdc("flag 16-bit", 8'h40, 32'h00000001);
      chk("dma pulses", 32'h00000001, dma_n);
      chk("trigger from low", 32'h00000000, trig_n);
      wr(8'h40, 32'h00000001);
      rdc("flag cleared", 8'h40, 32'h00000000);
      $display("test 16-bit match done");
      wr(8'h04, 32'h0000FFFF);
      wr(8'h14, 32'h00001234);
      wr(8'h00, 32'h00008008);
      repeat (5) @(posedge ref_clk);
      wr(8'h00, 32'h00000000);
      rdc("carry", 8'h14, 32'h00001235);
      chk("time base high", 32'h00001235, {16'h0, tb_count_high});
      rdc("carry low", 8'h04, 32'h00000007);
      chk("time base low", 32'h00000007, {16'h0, tb_count_low});
      $display("test carry done");
      wr(8'h04, 32'h0000FFFE);
      wr(8'h14, 32'h00000000);
      wr(8'h08, 32'h00000002);
      wr(8'h18, 32'h00000001);
      wr(8'h00, 32'h00008008);
      wr(8'h10, 32'h00008008);
      wflag(1);
      rdc("high ctrl", 8'h10, 32'h00008000);
      wr(8'h10, 32'h00000000);
      wr(8'h00, 32'h00000000);
      rdc("flag 32-bit", 8'h40, 32'h00000002);
      chk("trigger 32-bit", 32'h00000001, trig_n);
      wr(8'h40, 32'h0000000F);
      $display("test 32-bit match done");
      wr(8'h28, 32'h00000002);
      wr(8'h20, 32'h00008010);
      repeat (16) @(posedge ref_clk);
      chk("prescale early", 32'h00000000, {31'h0, timer_flag[2]});
      repeat (30) @(posedge ref_clk);
      chk("prescale late", 32'h00000001, {31'h0, timer_flag[2]});
      wr(8'h20, 32'h00000000);
      wr(8'h40, 32'h0000000F);
      $display("test prescale done");
      sleep_mode <= 1'b1;
      wr(8'h38, 32'h00000003);
      wr(8'h30, 32'h00008002);
      u_pin_source.edges(3, 2);
      repeat (6) @(posedge ref_clk);
      rdc("external in sleep", 8'h34, 32'h00000002);
      wr(8'h30, 32'h00000000);
      wr(8'h04, 32'h00000000);
      wr(8'h00, 32'h00008000);
      repeat (5) @(posedge ref_clk);
      rdc("internal in sleep", 8'h04, 32'h00000000);
      wr(8'h00, 32'h00000000);
      sleep_mode <= 1'b0;
      wr(8'h24, 32'h00000000);
      wr(8'h28, 32'h00000064);
      wr(8'h20, 32'h00008040);
      repeat (10) @(posedge ref_clk);
      rdc("gate low", 8'h24, 32'h00000000);
      u_pin_source.gate_set(2, 1'b1);
      repeat (10) @(posedge ref_clk);
      u_pin_source.gate_set(2, 1'b0);
      repeat (5) @(posedge ref_clk);
      rdc("gate high", 8'h24, 32'h0000000B);
      wr(8'h20, 32'h00000000);
      idle_mode <= 1'b1;
      wr(8'h04, 32'h00000000);
      wr(8'h00, 32'h0000A000);
      repeat (10) @(posedge ref_clk);
      rdc("idle stop", 8'h04, 32'h00000000);
      wr(8'h00, 32'h00008000);
      repeat (5) @(posedge ref_clk);
      chk("idle run", 32'h00000001, {31'h0, timer_flag[0]});
      wr(8'h00, 32'h00000000);
      idle_mode <= 1'b0;
      $display("test pins and power done");
      wrap_up;
   end

   initial
   begin
      repeat (3000) @(posedge ref_clk);
      n_mismatch++;
      wrap_up;
   end
endmodule
